// File: tqs_qual.sv
`timescale 1ns/1ps
package tqs_pkg;
  // Sampled bus layout
  localparam int unsigned BUS_W     = 80;
  localparam int unsigned ADDR_LSB  = 0;
  localparam int unsigned DATA_LSB  = 32;
  localparam int unsigned STAT_LSB  = 64;
  localparam int unsigned FIELD_W   = 32;
  localparam int unsigned STAT_W    = 16;
  // Sequencer sizing
  localparam int unsigned NUM_TERMS = 7;
  localparam int unsigned WIN_TERMS = 4;
  localparam int unsigned OCC_W     = 16;
  localparam int unsigned TERM_W    = 3;
  // Qualifier slots: terms 0..6, then restart, enable, disable
  localparam int unsigned NUM_QUAL  = 10;
  localparam int unsigned Q_RESTART = 7;
  localparam int unsigned Q_ENABLE  = 8;
  localparam int unsigned Q_DISABLE = 9;
  // Range comparator field select codes
  localparam logic [1:0] RSEL_ADDR = 2'h0;
  localparam logic [1:0] RSEL_DATA = 2'h1;
  localparam logic [1:0] RSEL_STAT = 2'h2;
  // Values after reset, and term-count limits
  localparam logic [BUS_W:0]      RST_BUS  = '0;
  localparam logic [TERM_W-1:0]   RST_TERM = 3'h0;
  localparam logic [OCC_W-1:0]    RST_CNT  = 16'h0000;
  localparam logic [TERM_W-1:0]   MAX_LEN  = 3'h7;
  localparam logic [TERM_W-1:0]   WIN_LEN  = 3'h4;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    TQS_IDLE   = 3'b001,
    TQS_SEARCH = 3'b010,
    TQS_DONE   = 3'b100
  } tqs_state_e;
endpackage

// One bus-state qualifier: pattern compare ORed with the shared range result
module tqs_qual (
  // Sampled state
  input  wire logic [tqs_pkg::BUS_W-1:0] sample_in,
  // Pattern setup
  input  wire logic [tqs_pkg::BUS_W-1:0] val_in,
  input  wire logic [tqs_pkg::BUS_W-1:0] mask_in,
  input  wire logic                      pat_en_in,
  // Range contribution
  input  wire logic                      rng_or_in,
  input  wire logic                      rng_hit_in,
  // Result
  output logic                           match_out
);
  logic pat_hit;  // Every compared bit agrees

  // All masked address, data and status bits must hold together
  assign pat_hit   = pat_en_in && (((sample_in ^ val_in) & mask_in) == '0);
  // Range result ORed into this qualifier
  assign match_out = pat_hit || (rng_or_in && rng_hit_in);
endmodule

// File: tqs_seq.sv
`timescale 1ns/1ps
// What this block does
// - Qualifier matches when all comparisons hold.
// - Range comparator on address, data or status, invertible.
// - Only one range comparator exists overall.
// - Range result ORs with other qualifiers.
// - Up to seven terms including trigger.
// - Term needs programmed occurrence count to advance.
// - Trigger only after all terms in order.
// - Windowing limits sequencer to four terms.
// - Restart match returns to first term.
// - Restart checked on every new bus cycle while searching, unless windowing is on.
// - Enable only: trace after enable match.
// - Enable plus disable: trace inside window.
// - 80 channels: 64 bus, 16 status.
module tqs_seq (
  // Clock and reset
  input  wire logic                         mclk_in,
  input  wire logic                         rst_n_in,
  // Sampled processor bus, asynchronous to mclk_in
  input  wire logic [tqs_pkg::BUS_W-1:0]    bus_state_in,
  input  wire logic                         bus_valid_in,
  // Measurement control
  input  wire logic                         start_in,
  // Qualifier setup
  input  wire logic [tqs_pkg::BUS_W-1:0]    qual_val_in  [tqs_pkg::NUM_QUAL],
  input  wire logic [tqs_pkg::BUS_W-1:0]    qual_mask_in [tqs_pkg::NUM_QUAL],
  input  wire logic [tqs_pkg::NUM_QUAL-1:0] qual_pat_en_in,
  input  wire logic [tqs_pkg::NUM_QUAL-1:0] qual_rng_or_in,
  // Range comparator setup
  input  wire logic [1:0]                   rng_sel_in,
  input  wire logic [tqs_pkg::FIELD_W-1:0]  rng_lo_in,
  input  wire logic [tqs_pkg::FIELD_W-1:0]  rng_hi_in,
  input  wire logic                         rng_inv_in,
  // Sequencer setup
  input  wire logic [tqs_pkg::TERM_W-1:0]   seq_len_in,
  input  wire logic [tqs_pkg::OCC_W-1:0]    occ_need_in [tqs_pkg::NUM_TERMS],
  input  wire logic                         restart_en_in,
  // Windowing setup
  input  wire logic                         win_en_in,
  input  wire logic                         win_dis_en_in,
  // Results
  output logic                              trigger_out,
  output logic                              trace_store_out,
  output logic                              searching_out,
  output logic [tqs_pkg::TERM_W-1:0]        seq_term_out,
  output logic                              window_open_out
);

  // Whole state of the block
  typedef struct packed {
    logic [tqs_pkg::BUS_W:0]         sync1;   // First synchroniser stage
    logic [tqs_pkg::BUS_W:0]         sync2;   // Second stage
    logic [tqs_pkg::BUS_W:0]         sync3;   // Third stage
    logic [tqs_pkg::BUS_W:0]         held;    // Accepted, settled bus state
    logic                            vprev;   // Valid seen last cycle
    tqs_pkg::tqs_state_e             state;   // Sequencer state
    logic [tqs_pkg::TERM_W-1:0]      term;    // Term being searched
    logic [tqs_pkg::OCC_W-1:0]       cnt;     // Occurrences of current term
    logic                            win;     // Window open
    logic                            trig;    // Trigger seen
    logic                            store;   // State traced this cycle
  } tqs_st_s;

  tqs_st_s st_q;   // Registered state
  tqs_st_s st_d;   // Next state

  logic [tqs_pkg::BUS_W-1:0]    smp;       // Settled bus state
  logic                         ev;        // One new bus cycle to judge
  logic                         rng_hit;   // Shared range comparator result
  logic [tqs_pkg::NUM_QUAL-1:0] qm;        // Qualifier matches
  logic [tqs_pkg::TERM_W-1:0]   len;       // Effective term count
  logic [tqs_pkg::TERM_W-1:0]   last;      // Index of trigger term
  logic [tqs_pkg::OCC_W-1:0]    need;      // Occurrences wanted for term
  logic                         rst_on;    // Restart is usable

  // Inclusive range check on the chosen field, optionally inverted
  function automatic logic in_range(input logic [tqs_pkg::BUS_W-1:0]   s,
                                    input logic [1:0]                  sel,
                                    input logic [tqs_pkg::FIELD_W-1:0] lo,
                                    input logic [tqs_pkg::FIELD_W-1:0] hi,
                                    input logic                        inv);
    logic [tqs_pkg::FIELD_W-1:0] f;
    f = '0;
    case (sel)
      tqs_pkg::RSEL_ADDR: f = s[tqs_pkg::ADDR_LSB +: tqs_pkg::FIELD_W];
      tqs_pkg::RSEL_DATA: f = s[tqs_pkg::DATA_LSB +: tqs_pkg::FIELD_W];
      tqs_pkg::RSEL_STAT: f = {16'h0000, s[tqs_pkg::STAT_LSB +: tqs_pkg::STAT_W]};
      default:            f = '0;
    endcase
    return ((f >= lo) && (f <= hi)) ^ inv;
  endfunction

  // Settled 80-channel sample and the new-cycle event
  assign smp     = st_q.held[tqs_pkg::BUS_W-1:0];
  assign ev      = st_q.held[tqs_pkg::BUS_W] && !st_q.vprev;
  // The single range comparator, shared by every qualifier
  assign rng_hit = in_range(smp, rng_sel_in, rng_lo_in, rng_hi_in, rng_inv_in);

  // One evaluator per qualifier slot
  genvar gi;
  generate
    for (gi = 0; gi < tqs_pkg::NUM_QUAL; gi++)
    begin : g_qual
      tqs_qual u_qual (
        .sample_in  (smp),
        .val_in     (qual_val_in[gi]),
        .mask_in    (qual_mask_in[gi]),
        .pat_en_in  (qual_pat_en_in[gi]),
        .rng_or_in  (qual_rng_or_in[gi]),
        .rng_hit_in (rng_hit),
        .match_out  (qm[gi])
      );
    end
  endgenerate

  // Effective sequence length and occurrence target
  always_comb
  begin
    len = seq_len_in;
    if (len == 3'h0)
    begin
      len = 3'h1;                              // At least the trigger term
    end
    if (win_en_in && (len > tqs_pkg::WIN_LEN))
    begin
      len = tqs_pkg::WIN_LEN;
    end
    last   = len - 3'h1;                       // Seven terms at most
    need   = occ_need_in[st_q.term];
    if (need == 16'h0000)
    begin
      need = 16'h0001;                         // Zero counts as one
    end
    rst_on = restart_en_in && !win_en_in;      // No restart with windowing
  end

  // Next-state logic for synchroniser, sequencer and window
  always_comb
  begin
    st_d       = st_q;
    st_d.store = 1'b0;
    // Three-stage pin synchroniser; take a value once stages two and three agree
    st_d.sync1 = {bus_valid_in, bus_state_in};
    st_d.sync2 = st_q.sync1;
    st_d.sync3 = st_q.sync2;
    if (st_q.sync2 == st_q.sync3)
    begin
      st_d.held = st_q.sync3;
    end
    st_d.vprev = st_q.held[tqs_pkg::BUS_W];

    if (start_in)
    begin
      // New measurement: clear term, count, window and trigger; start searching
      st_d.state = tqs_pkg::TQS_SEARCH;
      st_d.term  = tqs_pkg::RST_TERM;
      st_d.cnt   = tqs_pkg::RST_CNT;
      st_d.win   = 1'b0;
      st_d.trig  = 1'b0;
    end
    else if (ev && (st_q.state != tqs_pkg::TQS_IDLE))
    begin
      // Windowing: enable opens, disable closes a later open window
      if (win_en_in)
      begin
        if (!st_q.win && qm[tqs_pkg::Q_ENABLE])
        begin
          st_d.win   = 1'b1;
          st_d.store = 1'b1;
        end
        else if (st_q.win)
        begin
          st_d.store = 1'b1;
          if (win_dis_en_in && qm[tqs_pkg::Q_DISABLE])
          begin
            st_d.win = 1'b0;
          end
        end
      end
      else
      begin
        st_d.store = 1'b1;                     // No window: every state traced
      end

      // Sequencer
      case (st_q.state)
        tqs_pkg::TQS_SEARCH:
        begin
          if (rst_on && qm[tqs_pkg::Q_RESTART])
          begin
            // Restart wins over any term match
            st_d.term = tqs_pkg::RST_TERM;
            st_d.cnt  = tqs_pkg::RST_CNT;
          end
          else if (qm[st_q.term])
          begin
            if (st_q.term == last)
            begin
              st_d.trig  = 1'b1;
              st_d.state = tqs_pkg::TQS_DONE;
            end
            else if (({1'b0, st_q.cnt} + 17'h00001) >= {1'b0, need})
            begin
              st_d.term = st_q.term + 3'h1;
              st_d.cnt  = tqs_pkg::RST_CNT;
            end
            else
            begin
              st_d.cnt = st_q.cnt + 16'h0001;  // Count another occurrence
            end
          end
        end
        tqs_pkg::TQS_DONE:
        begin
          st_d.trig = 1'b1;                    // Trigger holds until next start_in
        end
        default:
        begin
          st_d.state = tqs_pkg::TQS_IDLE;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_q <= '{sync1: tqs_pkg::RST_BUS, sync2: tqs_pkg::RST_BUS,
                sync3: tqs_pkg::RST_BUS, held: tqs_pkg::RST_BUS,
                vprev: 1'b0, state: tqs_pkg::TQS_IDLE,
                term: tqs_pkg::RST_TERM, cnt: tqs_pkg::RST_CNT,
                win: 1'b0, trig: 1'b0, store: 1'b0};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Outputs straight from state flops
  assign trigger_out     = st_q.trig;
  assign trace_store_out = st_q.store;
  assign searching_out   = st_q.state[1];   // One-hot search bit, no decode
  assign seq_term_out    = st_q.term;
  assign window_open_out = st_q.win;
endmodule

// File: tqs_seq_assertions.sv
`timescale 1ns/1ps
// Watches sequencer, trigger and window outputs
module tqs_seq_assertions (
  // Clock, reset and setup
  input wire logic       mclk_in,
  input wire logic       rst_n_in,
  input wire logic       start_in,
  input wire logic       restart_en_in,
  input wire logic       win_en_in,
  // Results
  input wire logic       trigger_out,
  input wire logic       trace_store_out,
  input wire logic       searching_out,
  input wire logic [2:0] seq_term_out,
  input wire logic       window_open_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  property p_start; start_in |=> searching_out && seq_term_out == 3'h0 && !trigger_out && !window_open_out; endproperty
  a_start: assert property (p_start) else $error("start left state");
  property p_hold; trigger_out && !start_in |=> trigger_out; endproperty
  a_hold: assert property (p_hold) else $error("trigger dropped");
  property p_done; trigger_out |-> !searching_out; endproperty
  a_done: assert property (p_done) else $error("search after trigger");
  property p_rise; $rose(trigger_out) |-> $past(searching_out); endproperty
  a_rise: assert property (p_rise) else $error("trigger while idle");
  property p_max; searching_out |-> seq_term_out <= 3'h6; endproperty
  a_max: assert property (p_max) else $error("term past seven");
  property p_win4; win_en_in && searching_out |-> seq_term_out <= 3'h3; endproperty
  a_win4: assert property (p_win4) else $error("term past four");
  property p_step;
    searching_out && $changed(seq_term_out) && seq_term_out != 3'h0 |-> seq_term_out == $past(seq_term_out) + 3'h1;
  endproperty
  a_step: assert property (p_step) else $error("term skipped");
  property p_rst;
    searching_out && $changed(seq_term_out) && seq_term_out == 3'h0 && !$past(start_in)
      |-> $past(restart_en_in) && !$past(win_en_in);
  endproperty
  a_rst: assert property (p_rst) else $error("bad return to first term");
  property p_win; trace_store_out && win_en_in |-> window_open_out || $past(window_open_out); endproperty
  a_win: assert property (p_win) else $error("traced outside window");
  // Main scenarios reached
  c_trig: cover property ($rose(trigger_out));
  c_win: cover property ($rose(window_open_out));
  c_rst: cover property (restart_en_in && $changed(seq_term_out) && seq_term_out == 3'h0);
endmodule

bind tqs_seq tqs_seq_assertions u_chk (.mclk_in, .rst_n_in, .start_in, .restart_en_in, .win_en_in,
  .trigger_out, .trace_store_out, .searching_out, .seq_term_out, .window_open_out);

// File: tqs_bus_model.sv
`timescale 1ns/1ps
// Processor bus as sampled: one bus cycle per send
module tqs_bus_model (
  // Sample clock
  input  wire logic        mclk_in,
  // Bus state and cycle marker
  output logic      [79:0] bus_state_out,
  output logic             bus_valid_out
);
  // Idle bus at time zero
  initial
  begin
    bus_state_out = 80'h0;
    bus_valid_out = 1'b0;
  end
  // Holds state past the sync, then drops valid and scrambles the lines
  task automatic send(input logic [79:0] s);
    @(posedge mclk_in);
    bus_state_out <= s;
    bus_valid_out <= 1'b1;
    repeat (6) @(posedge mclk_in);
    bus_valid_out <= 1'b0;
    @(posedge mclk_in);
    bus_state_out <= ~s;
    repeat (6) @(posedge mclk_in);
  endtask
endmodule

// File: tqs_seq_tb.sv
`timescale 1ns/1ps
module tqs_seq_tb;
  // Stimulus and setup
  logic        mclk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        start_in = 1'b0;
  logic [79:0] bus_state;
  logic        bus_valid;
  logic [79:0] qv [10];
  logic [79:0] qm [10];
  logic [15:0] occ [7];
  logic [9:0]  ror = 10'h000;
  logic        rinv = 1'b0;
  logic [1:0]  rsel = 2'h1;
  logic [2:0]  len = 3'h7;
  logic        ren = 1'b0;
  logic        wen = 1'b0;
  logic        wdis = 1'b0;
  // Results and tallies
  logic        trig;
  logic        store;
  logic        srch;
  logic        wopen;
  logic [2:0]  term;
  int          bad_count = 0;
  int          compares = 0;
  int          stores = 0;
  // Range cases: inverted, expected, address byte, data byte
  logic [19:0] tbl [8] = '{20'h00005, 20'h10006, 20'h10026, 20'h00027,
                           20'h17729, 20'h00029, 20'h30005, 20'h20006};
  tqs_bus_model u_bus (.mclk_in, .bus_state_out(bus_state), .bus_valid_out(bus_valid));
  tqs_seq dut (.mclk_in, .rst_n_in, .start_in, .bus_state_in(bus_state), .bus_valid_in(bus_valid),
    .qual_val_in(qv), .qual_mask_in(qm), .qual_pat_en_in(10'h3FF), .qual_rng_or_in(ror),
    .rng_sel_in(rsel), .rng_lo_in(32'h00000006), .rng_hi_in(32'h00000026), .rng_inv_in(rinv),
    .seq_len_in(len), .occ_need_in(occ), .restart_en_in(ren), .win_en_in(wen), .win_dis_en_in(wdis),
    .trigger_out(trig), .trace_store_out(store), .searching_out(srch), .seq_term_out(term),
    .window_open_out(wopen));
  // 40 MHz clock
  initial
  begin
    forever #12.5 mclk_in = ~mclk_in;
  end
  // Counts traced states
  always @(posedge mclk_in)
    if (store === 1'b1) stores++;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("FAIL %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (bad_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // New measurement with given length, restart and window setup
  task automatic go(input logic [2:0] l, input logic r, input logic w, input logic d);
    @(posedge mclk_in);
    {len, ren, wen, wdis} <= {l, r, w, d};
    start_in <= 1'b1;
    @(posedge mclk_in);
    start_in <= 1'b0;
  endtask
  task automatic ev(input logic [31:0] a, input logic [31:0] d = 32'h0);
    u_bus.send({16'h0000, d, a});
  endtask
  // Seven terms, two occurrences each before the trigger term, out-of-order state ignored
  task automatic s_seq();
    go(3'h7, 1'b0, 1'b0, 1'b0);
    ev(32'h12);
    check(term, 3'h0);
    for (int i = 0; i < 6; i++)
    begin
      ev(32'h10 + i);
      check(term, i);
      ev(32'h10 + i);
      check(term, i + 1);
    end
    ev(32'h16);
    check({srch, trig}, 2'h1);
  endtask
  // Restart drops progress and the partial count
  task automatic s_restart();
    go(3'h7, 1'b1, 1'b0, 1'b0);
    ev(32'h10);
    ev(32'h10);
    ev(32'h11);
    ev(32'h17);
    check(term, 3'h0);
    ev(32'h10);
    check({trig, term}, 4'h0);
  endtask
  // Enable and disable window, four-term limit, restart ignored
  task automatic s_window();
    go(3'h7, 1'b1, 1'b1, 1'b1);
    stores = 0;
    ev(32'h30);
    ev(32'h18);
    check(wopen, 1'b1);
    ev(32'h30);
    ev(32'h19);
    check(wopen, 1'b0);
    ev(32'h30);
    check(stores, 3);
    for (int i = 0; i < 6; i++)
      ev(32'h10 + i / 2);
    ev(32'h17);
    check(term, 3'h3);
    ev(32'h13);
    check(trig, 1'b1);
    go(3'h2, 1'b0, 1'b1, 1'b0);
    ev(32'h18);
    ev(32'h19);
    check(wopen, 1'b1);
  endtask
  // One range case on the given field, range not inverted
  task automatic r_case(input logic [1:0] s, input logic [79:0] b, input logic e);
    @(posedge mclk_in);
    rsel <= s;
    rinv <= 1'b0;
    go(3'h1, 1'b0, 1'b0, 1'b0);
    u_bus.send(b);
    check(trig, e);
  endtask
  // Data range ORed with an address plus data pattern
  task automatic s_range();
    @(posedge mclk_in);
    qv[0] <= {16'h0000, 32'h00000029, 32'h00000077};
    qm[0] <= {16'h0000, 32'hFFFFFFFF, 32'hFFFFFFFF};
    ror <= 10'h001;
    foreach (tbl[i])
    begin
      @(posedge mclk_in);
      rinv <= tbl[i][17];
      go(3'h1, 1'b0, 1'b0, 1'b0);
      ev({24'h000000, tbl[i][15:8]}, {24'h000000, tbl[i][7:0]});
      check(trig, tbl[i][16]);
    end
    // Address and status fields, and the unused code reading zero
    r_case(2'h0, {16'h0000, 32'h00000010, 32'h00000027}, 1'b0);
    r_case(2'h0, {16'h0000, 32'h00000000, 32'h00000010}, 1'b1);
    r_case(2'h2, {16'h0010, 32'h00000000, 32'h00000027}, 1'b1);
    r_case(2'h2, {16'h0030, 32'h00000010, 32'h00000010}, 1'b0);
    r_case(2'h3, {16'h0010, 32'h00000010, 32'h00000010}, 1'b0);
  endtask
  // Main sequence
  initial
  begin
    foreach (qv[i])
    begin
      qv[i] = {48'h0, 32'h10 + i};
      qm[i] = 80'hFFFFFFFF;
    end
    foreach (occ[i])
      occ[i] = 16'h0002;
    repeat (16) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    s_seq();
    s_restart();
    s_window();
    s_range();
    close_out();
  end
  // Watchdog well past the expected run
  initial
  begin
    repeat (20000) @(posedge mclk_in);
    bad_count++;
    close_out();
  end
endmodule
